// >>> verilog/otic_map.vh
`ifndef OTIC_MAP_VH
`define OTIC_MAP_VH
// =====================================================================
// stream and tag widths
`define OTIC_STREAMS 32
`define OTIC_SEC_W 32
`define OTIC_CYC_W 27
// =====================================================================
// rate select codes: rate = 2 Mbps shifted left by code
`define OTIC_RATE_2M 3'h0
`define OTIC_RATE_32M 3'h4
`define OTIC_RATE_128M 3'h6
// cycles of the input clock in one second at the 2 Mbps code
`define OTIC_BASE_CYC_PER_SEC 32'h001e8480
// =====================================================================
// fifo shape
`define OTIC_FIFO_DEPTH 4
// =====================================================================
// reset values
`define OTIC_RST_SEC 32'h00000000
`define OTIC_RST_CYC 27'h0000000
`endif

// >>> verilog/otic_capture.v
// What this block does
// R1: sample 32 streams at 2 to 32 Mbps
// R2: optional 64 and 128 Mbps rate codes
// R3: source keeps all streams one rate
// R4: capture all streams on shared clock
// R5: tick-coincident bit tagged with that second
// R6: alternate async tick selectable as substitute
// R7: validity line carried through, uninterpreted
// R8: aux text bursts bounded per second
// R9: counter tags each bit per cycle
// R10: load commanded second on chosen tick
// R11: after load count cycles, ignore ticks
// R12: one tag shared by all streams
// R13: tag applied before forwarding streams
// R14: command and monitor control port
// R15: tick notify and timed replies
// R16: forward only selected stream subset
// R17: second mark pulse from counter
// R18: report counter at next second mark
// R19: synchronise alternate tick, detect rise
// R20: seconds plus wrapping sub-second cycles
`timescale 1ns/1ps
`include "otic_map.vh"

// =====================================================================
// small flop fifo with valid/ready on both sides
module otic_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk,
  input wire srst,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wrPtr_q;
  reg [AW-1:0] rdPtr_q;
  reg [AW:0] count_q;
  wire doWrite;
  wire doRead;
  integer i;

  // honest full and empty from the occupancy count
  assign inReady = (count_q != DEPTH[AW:0]);
  assign outValid = (count_q != {(AW+1){1'b0}});
  assign outData = mem_q[rdPtr_q];
  assign doWrite = inValid & inReady;
  assign doRead = outValid & outReady;

  // pointers wrap by index; depth must be a power of two
  always @(posedge clk)
  begin
    if (srst)
    begin
      wrPtr_q <= {AW{1'b0}};
      rdPtr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1)
        mem_q[i] <= {WIDTH{1'b0}};
    end
    else
    begin
      if (doWrite)
      begin
        mem_q[wrPtr_q] <= inData;
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (doRead)
        rdPtr_q <= rdPtr_q + 1'b1;
      if (doWrite & ~doRead)
        count_q <= count_q + 1'b1;
      else if (doRead & ~doWrite)
        count_q <= count_q - 1'b1;
    end
  end
endmodule

// =====================================================================
// input capture with observe-time counter
module otic_capture #(
  parameter NS = `OTIC_STREAMS,
  parameter SW = `OTIC_SEC_W,
  parameter CW = `OTIC_CYC_W,
  parameter [31:0] BASE_CYC_PER_SEC = `OTIC_BASE_CYC_PER_SEC,
  parameter EXT_RATES = 1,
  parameter FIFO_DEPTH = `OTIC_FIFO_DEPTH,
  parameter FIFO_AW = 2
) (
  input wire clk,
  input wire srst,
  input wire inputClock,
  input wire [NS-1:0] parallelBitStream,
  input wire secondTick,
  input wire alternateSecondTick,
  input wire inputValidity,
  input wire auxSerialText,
  input wire [2:0] rateSel,
  input wire [NS-1:0] streamSelect,
  input wire useAlternateTick,
  input wire setCmd,
  input wire [SW-1:0] setSecond,
  input wire reportCmd,
  input wire xmitEnable,
  input wire overflowClear,
  output reg tickNotify,
  output reg observeTimeSecondMark,
  output reg reportValid,
  output reg [SW-1:0] reportSecond,
  output reg timeSet,
  output reg setPending,
  output reg overflow,
  output reg auxSerialOut,
  output wire tagValid,
  input wire tagReady,
  output wire [SW-1:0] tagSecond,
  output wire [CW-1:0] tagCycle,
  output wire tagValidity,
  output wire [NS-1:0] tagStreams
);
  localparam FW = 1 + SW + CW + NS;

  // two-flop synchronisers for everything from the pins
  reg [2:0] clkSync_q;
  reg [NS-1:0] dataS1_q;
  reg [NS-1:0] dataS2_q;
  reg [1:0] tickSync_q;
  reg [1:0] validSync_q;
  reg [2:0] altSync_q;
  reg [1:0] auxSync_q;
  wire linkEdge;
  wire altEdge;

  // observe-time counter state
  reg [SW-1:0] sec_q;
  reg [CW-1:0] cyc_q;
  reg altPend_q;
  reg reportArm_q;
  reg [2:0] rateEff;
  reg [31:0] cycPerSec;
  reg [CW-1:0] lastCyc;
  reg [SW-1:0] tagSec;
  reg [CW-1:0] tagCyc;
  reg loadNow;
  reg primaryHit;

  // capture word toward the fifo
  reg [FW-1:0] word_q;
  reg wordValid_q;
  wire fifoInReady;
  wire [FW-1:0] fifoOut;

  // =====================================================================
  // pin synchronisers
  // R4: shared clock sampling
  always @(posedge clk)
  begin
    if (srst)
    begin
      clkSync_q <= 3'h0;
      dataS1_q <= {NS{1'b0}};
      dataS2_q <= {NS{1'b0}};
      tickSync_q <= 2'h0;
      validSync_q <= 2'h0;
      altSync_q <= 3'h0;
      auxSync_q <= 2'h0;
    end
    else
    begin
      clkSync_q <= {clkSync_q[1:0], inputClock};
      dataS1_q <= parallelBitStream;
      dataS2_q <= dataS1_q;
      tickSync_q <= {tickSync_q[0], secondTick};
      validSync_q <= {validSync_q[0], inputValidity};
      altSync_q <= {altSync_q[1:0], alternateSecondTick};
      auxSync_q <= {auxSync_q[0], auxSerialText};
    end
  end

  // edges read only the second and third stages
  assign linkEdge = clkSync_q[1] & ~clkSync_q[2];
  // R19: alternate tick rise
  assign altEdge = altSync_q[1] & ~altSync_q[2];

  // =====================================================================
  // rate and tag computation
  always @*
  begin
    // R1: base rates; R2: extension codes
    rateEff = rateSel;
    if (rateSel > `OTIC_RATE_128M)
      rateEff = `OTIC_RATE_128M;
    if ((EXT_RATES == 0) && (rateSel > `OTIC_RATE_32M))
      rateEff = `OTIC_RATE_32M;
    // R20: cycles in one second follow the rate
    cycPerSec = BASE_CYC_PER_SEC << rateEff;
    lastCyc = cycPerSec[CW-1:0] - 1'b1;
    // R10: primary tick is seen with its own data bit
    primaryHit = tickSync_q[1] & ~useAlternateTick;
    loadNow = setPending & (primaryHit | (altPend_q & useAlternateTick));
    // R5: the coincident bit carries the new second, cycle zero
    if (loadNow)
    begin
      tagSec = setSecond;
      tagCyc = `OTIC_RST_CYC;
    end
    else
    begin
      tagSec = sec_q;
      tagCyc = cyc_q;
    end
  end

  // =====================================================================
  // observe-time counter and command handling
  always @(posedge clk)
  begin
    if (srst)
    begin
      sec_q <= `OTIC_RST_SEC;
      cyc_q <= `OTIC_RST_CYC;
      timeSet <= 1'b0;
      setPending <= 1'b0;
      altPend_q <= 1'b0;
    end
    else
    begin
      // R14: a set command arms the next chosen tick
      if (setCmd)
        setPending <= 1'b1;
      // R6: remember an alternate edge until the next bit
      if (altEdge & setPending & useAlternateTick)
        altPend_q <= 1'b1;
      if (linkEdge)
      begin
        if (loadNow)
        begin
          // R10: load the commanded second
          setPending <= setCmd;
          altPend_q <= 1'b0;
          timeSet <= 1'b1;
        end
        // R11: free run on cycles, ticks ignored
        // R20: wrap sub-second count into seconds
        if (tagCyc >= lastCyc)
        begin
          cyc_q <= `OTIC_RST_CYC;
          sec_q <= tagSec + 1'b1;
        end
        else
        begin
          cyc_q <= tagCyc + 1'b1;
          sec_q <= tagSec;
        end
      end
    end
  end

  // =====================================================================
  // monitor outputs
  always @(posedge clk)
  begin
    if (srst)
    begin
      tickNotify <= 1'b0;
      observeTimeSecondMark <= 1'b0;
      reportValid <= 1'b0;
      reportSecond <= `OTIC_RST_SEC;
      reportArm_q <= 1'b0;
      auxSerialOut <= 1'b0;
    end
    else
    begin
      // R15: notify the controller of each selected tick
      tickNotify <= useAlternateTick ? altEdge : (linkEdge & tickSync_q[1]);
      // R17: mark on cycle zero of a set counter
      observeTimeSecondMark <= linkEdge & (timeSet | loadNow)
        & (tagCyc == `OTIC_RST_CYC);
      // R18: report at next mark; new request wins over completion
      reportValid <= 1'b0;
      if (reportArm_q & linkEdge & (timeSet | loadNow)
        & (tagCyc == `OTIC_RST_CYC))
      begin
        reportValid <= 1'b1;
        reportSecond <= tagSec;
        reportArm_q <= reportCmd;
      end
      else if (reportCmd)
        reportArm_q <= 1'b1;
      // aux text passed on untouched, no framing here
      auxSerialOut <= auxSync_q[1];
    end
  end

  // =====================================================================
  // tagged capture word into the fifo
  always @(posedge clk)
  begin
    if (srst)
    begin
      word_q <= {FW{1'b0}};
      wordValid_q <= 1'b0;
      overflow <= 1'b0;
    end
    else
    begin
      wordValid_q <= 1'b0;
      if (linkEdge & xmitEnable & (timeSet | loadNow))
      begin
        // R9: tag per cycle
        // R12: one tag for all streams
        // R13: tag joined before forwarding
        // R16: unselected streams forced low
        // R7: validity rides along unchanged
        word_q <= {validSync_q[1], tagSec, tagCyc,
          dataS2_q & streamSelect};
        wordValid_q <= 1'b1;
      end
      // a stalled drain drops words; set beats clear
      if (wordValid_q & ~fifoInReady)
        overflow <= 1'b1;
      else if (overflowClear)
        overflow <= 1'b0;
    end
  end

  // =====================================================================
  // output buffer
  otic_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .srst(srst),
    .inValid(wordValid_q),
    .inReady(fifoInReady),
    .inData(word_q),
    .outValid(tagValid),
    .outReady(tagReady),
    .outData(fifoOut)
  );

  assign tagValidity = fifoOut[FW-1];
  assign tagSecond = fifoOut[FW-2:CW+NS];
  assign tagCycle = fifoOut[CW+NS-1:NS];
  assign tagStreams = fifoOut[NS-1:0];
endmodule

// >>> verif/otic_asserts.sv
`timescale 1ns/1ps
// =====================================================================
// port checker for the capture block
module otic_capture_asserts #(
  parameter SW = 32
) (
  input logic clk,
  input logic srst,
  input logic setCmd,
  input logic tickNotify,
  input logic observeTimeSecondMark,
  input logic reportValid,
  input logic [SW-1:0] reportSecond,
  input logic timeSet,
  input logic setPending,
  input logic tagValid
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  set_arm_a: assert property (setCmd |=> setPending)
    else $error("load not armed after set command");
  load_clears_a: assert property ($rose(timeSet) |-> !setPending
    || $past(setCmd))
    else $error("load left armed after loading");
  mark_set_a: assert property (observeTimeSecondMark |-> timeSet)
    else $error("second mark from an unset counter");
  mark_pulse_a: assert property (observeTimeSecondMark
    |=> !observeTimeSecondMark)
    else $error("second mark longer than one cycle");
  report_mark_a: assert property (reportValid |-> observeTimeSecondMark)
    else $error("report away from a second mark");
  report_hold_a: assert property (!reportValid |-> $stable(reportSecond))
    else $error("reported second moved without report");
  notify_pulse_a: assert property (tickNotify |=> !tickNotify)
    else $error("tick notify longer than one cycle");
  no_tag_unset_a: assert property (!timeSet |-> !tagValid)
    else $error("tagged word before counter was set");
endmodule
bind otic_capture otic_capture_asserts #(.SW(SW)) otic_capture_asserts_i (
  .clk(clk), .srst(srst), .setCmd(setCmd), .tickNotify(tickNotify),
  .observeTimeSecondMark(observeTimeSecondMark), .reportValid(reportValid),
  .reportSecond(reportSecond), .timeSet(timeSet), .setPending(setPending),
  .tagValid(tagValid)
);

// >>> verif/otic_source.sv
`timescale 1ns/1ps
// =====================================================================
// acquisition side: free link clock, streams and second tick
module otic_source (
  output logic inputClock,
  output logic [31:0] parallelBitStream,
  output logic secondTick,
  output logic inputValidity,
  output logic auxSerialText,
  output int idx,
  input int per,
  input logic [31:0] salt
);
  logic [7:0] ch;
  // odd start offset keeps the link unrelated to clk
  // clock starts high so time zero brings no false falling edge
  initial
  begin
    {inputClock, secondTick, inputValidity, auxSerialText} = 4'h9;
    parallelBitStream = 32'h0;
    idx = 0;
    #3;
    forever #40 inputClock = ~inputClock;
  end
  // shared rate and tick
  // lines move on the fall so the sampling rise sees them settled
  always @(negedge inputClock)
  begin
    idx = idx + 1;
    parallelBitStream = (idx * 32'h9e3779b9) ^ salt;
    inputValidity = parallelBitStream[7];
    secondTick = (idx % per) == 0;
    // framed ascii bytes, far fewer than 2048 per second
    ch = 8'h41 + 8'((idx / 10) % 26);
    auxSerialText = (idx % 10 == 0) ? 1'b0 :
      (idx % 10 == 9) ? 1'b1 : ch[idx % 10 - 1];
  end
endmodule

// >>> verif/otic_capture_tb.sv
`timescale 1ns/1ps
// =====================================================================
// bench top
module otic_capture_tb;
  logic clk = 1'b0, srst = 1'b1, alternateSecondTick = 1'b0;
  logic inputClock, secondTick, inputValidity, auxSerialText;
  logic [31:0] parallelBitStream, streamSelect, setSecond, salt, s0, s2;
  logic [31:0] tagSecond, tagStreams, reportSecond;
  logic [26:0] tagCycle;
  logic [2:0] rateSel;
  logic useAlternateTick = 1'b0, setCmd = 1'b0, reportCmd = 1'b0;
  logic xmitEnable = 1'b0, overflowClear = 1'b0, tagReady = 1'b0;
  logic tickNotify, observeTimeSecondMark, reportValid, timeSet, setPending;
  logic overflow, auxSerialOut, tagValid, tagValidity;
  logic chkOn = 1'b0, stall = 1'b0, sawS2 = 1'b0;
  logic aux1 = 1'b0, aux2 = 1'b0, aux3 = 1'b0;
  int idx, per, lo, k, n = 0, nTick = 0, num_errors = 0, total_checks = 0;
  otic_source otic_source_i (.inputClock(inputClock),
    .parallelBitStream(parallelBitStream), .secondTick(secondTick),
    .inputValidity(inputValidity), .auxSerialText(auxSerialText),
    .idx(idx), .per(per), .salt(salt));
  otic_capture #(.BASE_CYC_PER_SEC(32'h4)) otic_capture_i (.clk(clk),
    .srst(srst), .inputClock(inputClock), .secondTick(secondTick),
    .parallelBitStream(parallelBitStream), .rateSel(rateSel),
    .alternateSecondTick(alternateSecondTick), .setSecond(setSecond),
    .inputValidity(inputValidity), .auxSerialText(auxSerialText),
    .streamSelect(streamSelect), .useAlternateTick(useAlternateTick),
    .setCmd(setCmd), .reportCmd(reportCmd), .xmitEnable(xmitEnable),
    .overflowClear(overflowClear), .tickNotify(tickNotify),
    .observeTimeSecondMark(observeTimeSecondMark), .overflow(overflow),
    .reportValid(reportValid), .reportSecond(reportSecond),
    .timeSet(timeSet), .setPending(setPending), .tagValid(tagValid),
    .auxSerialOut(auxSerialOut), .tagReady(tagReady),
    .tagSecond(tagSecond), .tagCycle(tagCycle),
    .tagValidity(tagValidity), .tagStreams(tagStreams));
  always #4 clk = ~clk;
  function automatic logic [31:0] expStream(input int i);
    return (i * 32'h9e3779b9) ^ salt;
  endfunction
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // random drain stalls, full stop while overfilling
  always @(posedge clk) tagReady <= !stall && ($urandom % 4 != 0);
  // scoreboard on every word drained while chkOn is set
  always @(posedge clk)
  begin
    if (useAlternateTick === 1'b1 && tickNotify === 1'b1) nTick++;
    // aux line comes out three clocks later, untouched
    aux1 <= auxSerialText;
    aux2 <= aux1;
    aux3 <= aux2;
    if (chkOn) chk1(auxSerialOut, aux3);
    if (tagValid === 1'b1 && tagReady === 1'b1)
    begin
      if (tagSecond === s2 && tagCycle === 27'h0) sawS2 = 1'b1;
      if (chkOn)
      begin
        chk32(tagSecond, s0 + n / per);
        chk32({5'h0, tagCycle}, n % per);
        chk32(tagStreams, expStream(lo + n) & streamSelect);
        chk32({31'h0, tagValidity}, (expStream(lo + n) >> 7) & 1);
        n++;
      end
    end
  end
  // main sequence: set on primary tick, report, alternate set, overfill
  initial
  begin
    k = $urandom(97437);
    rateSel = 3'($urandom_range(7, 0));
    // codes above six run at the top extension rate
    per = 4 << ((rateSel > 3'h6) ? 3'h6 : rateSel);
    salt = $urandom;
    streamSelect = $urandom | 32'h80000001;
    s0 = $urandom & 32'h7fffffff;
    s2 = s0 + 32'h100;
    setSecond = 32'h0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    setSecond <= s0;
    xmitEnable <= 1'b1;
    setCmd <= 1'b1;
    @(posedge clk);
    setCmd <= 1'b0;
    for (k = 0; k < 12 * per + 40 && timeSet !== 1'b1; k++)
      @(posedge clk);
    chk1(timeSet, 1'b1);
    lo = idx;
    chk32(lo % per, 0);
    chkOn <= 1'b1;
    repeat (3000 + 24 * per) @(posedge clk);
    chk1(n > 2 * per, 1'b1);
    reportCmd <= 1'b1;
    @(posedge clk);
    reportCmd <= 1'b0;
    for (k = 0; k < 12 * per + 40 && reportValid !== 1'b1; k++)
      @(posedge clk);
    chk1(reportValid, 1'b1);
    chk32(reportSecond, s0 + (idx - lo) / per);
    chkOn <= 1'b0;
    useAlternateTick <= 1'b1;
    setSecond <= s2;
    setCmd <= 1'b1;
    @(posedge clk);
    setCmd <= 1'b0;
    repeat (7) @(posedge clk);
    #1 nTick = 0;
    @(posedge clk);
    alternateSecondTick <= 1'b1;
    repeat (20) @(posedge clk);
    alternateSecondTick <= 1'b0;
    repeat (60) @(posedge clk);
    chk1(setPending, 1'b0);
    chk1(sawS2, 1'b1);
    chk32(nTick, 1);
    stall <= 1'b1;
    repeat (120) @(posedge clk);
    chk1(overflow, 1'b1);
    stall <= 1'b0;
    // long enough for the drain to empty despite random stalls
    repeat (30) @(posedge clk);
    overflowClear <= 1'b1;
    @(posedge clk);
    overflowClear <= 1'b0;
    repeat (2) @(posedge clk);
    chk1(overflow, 1'b0);
    print_verdict();
  end
  // watchdog against a hang
  initial
  begin
    // about twice the longest run at the top rate code
    #(8 * 30000);
    num_errors++;
    print_verdict();
  end
endmodule
